/* File: inc/olst_defines.svh */
// register offsets, field positions, reset values and timing counts of the output line block
`ifndef OLST_DEFINES_SVH
`define OLST_DEFINES_SVH

`define OLST_RAW_W            12
`define OLST_TB_W             16
`define OLST_ABS_W            28
`define OLST_RAW_MAX          12'hFFF

`define OLST_ADDR_CTRL        8'h00
`define OLST_ADDR_DELAY_RAW   8'h04
`define OLST_ADDR_DELAY_TB    8'h08
`define OLST_ADDR_DUR_RAW     8'h0C
`define OLST_ADDR_DUR_TB      8'h10
`define OLST_ADDR_DUR_ABS     8'h14
`define OLST_ADDR_STATUS      8'h18

`define OLST_CTRL_SRC_LSB     0
`define OLST_CTRL_SRC_MSB     2
`define OLST_CTRL_INV_BIT     3
`define OLST_CTRL_USER_BIT    4
`define OLST_CTRL_STD_BIT     5

`define OLST_STAT_LINE_BIT    0
`define OLST_STAT_TMR_BIT     1
`define OLST_STAT_BUSY_BIT    2

`define OLST_RST_SRC          3'h2
`define OLST_RST_DELAY_RAW    12'h000
`define OLST_RST_DUR_RAW      12'h001
`define OLST_RST_TB           16'h0001

`define OLST_RESP_OKAY        2'h0
`define OLST_RESP_SLVERR      2'h2

`define OLST_US_NS            1000
`define OLST_CLK_NS           4
`define OLST_TICK_CYCLES      (`OLST_US_NS / `OLST_CLK_NS)

`endif

/* File: inc/olst_pkg.sv */
// types shared by the output line block
package olst_pkg;
  `include "olst_defines.svh"

  typedef logic [`OLST_RAW_W-1:0] olst_raw_t;
  typedef logic [`OLST_TB_W-1:0]  olst_tb_t;
  typedef logic [`OLST_ABS_W-1:0] olst_abs_t;

  typedef enum logic [2:0] {
    SRC_ACQ_WAIT   = 3'b000,
    SRC_TRIG_READY = 3'b001,
    SRC_EXP_ACTIVE = 3'b010,
    SRC_TIMER      = 3'b011,
    SRC_USER       = 3'b100
  } olst_src_e;

  typedef enum logic [1:0] {
    TMR_IDLE  = 2'b00,
    TMR_DELAY = 2'b01,
    TMR_DUR   = 2'b10
  } olst_tmr_e;

  // packed from the top bit down: mode, user level, invert, source
  typedef struct packed {
    logic       stdMode;
    logic       userLevel;
    logic       invert;
    logic [2:0] src;
  } olst_cfg_s;

  typedef struct packed {
    olst_raw_t delayRaw;
    olst_tb_t  delayTb;
    olst_raw_t durRaw;
    olst_tb_t  durTb;
  } olst_tmr_s;
endpackage

/* File: hdl/olst_timer.sv */
// delay and pulse timer driven by a one-microsecond tick
`timescale 1ns/1ns
`include "olst_defines.svh"
module olst_timer import olst_pkg::*; #(
  parameter int TICK_CYCLES = `OLST_TICK_CYCLES
) (
  // system
  input  wire logic      clock,
  input  wire logic      rstn,
  // control
  input  wire logic      trigger,
  input  wire olst_tmr_s set,
  // status
  output logic           timerOut,
  output logic           busy
);
  olst_tmr_e state_reg, stateNext;
  logic [15:0] preCnt_reg;
  olst_raw_t   unitCnt_reg, unitNext;
  olst_tb_t    baseCnt_reg, baseNext;
  logic        timerOut_reg;
  logic        busy_reg;

  wire logic tick      = (preCnt_reg == 16'(TICK_CYCLES - 1));
  wire logic lastBase  = tick && (baseCnt_reg <= 16'h0001);
  wire logic lastUnit  = lastBase && (unitCnt_reg <= 12'h001);
  wire logic zeroDelay = (set.delayRaw == 12'h000);
  // prescaler restarts with the timer so no period comes up short
  wire logic start     = trigger && (state_reg == TMR_IDLE);

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      preCnt_reg <= 16'h0000;
    end else begin
      preCnt_reg <= (tick || start) ? 16'h0000 : preCnt_reg + 16'h0001;
    end
  end

  always_comb begin
    stateNext = state_reg;
    unitNext  = unitCnt_reg;
    baseNext  = baseCnt_reg;
    unique case (state_reg)
      TMR_IDLE: begin
        // only exposure start arrives here
        if (trigger) begin
          stateNext = zeroDelay ? TMR_DUR : TMR_DELAY;
          unitNext  = zeroDelay ? set.durRaw : set.delayRaw;
          baseNext  = zeroDelay ? set.durTb : set.delayTb;
        end
      end
      TMR_DELAY: begin
        if (lastUnit) begin
          stateNext = TMR_DUR;
          unitNext  = set.durRaw;
          baseNext  = set.durTb;
        end else if (lastBase) begin
          unitNext = unitCnt_reg - 12'h001;
          baseNext = set.delayTb;
        end else if (tick) begin
          baseNext = baseCnt_reg - 16'h0001;
        end
      end
      TMR_DUR: begin
        if (lastUnit) begin
          stateNext = TMR_IDLE;
        end else if (lastBase) begin
          unitNext = unitCnt_reg - 12'h001;
          baseNext = set.durTb;
        end else if (tick) begin
          baseNext = baseCnt_reg - 16'h0001;
        end
      end
      default: begin
        stateNext = TMR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_reg    <= TMR_IDLE;
      unitCnt_reg  <= 12'h000;
      baseCnt_reg  <= 16'h0000;
      timerOut_reg <= 1'b0;
      busy_reg     <= 1'b0;
    end else begin
      state_reg    <= stateNext;
      unitCnt_reg  <= unitNext;
      baseCnt_reg  <= baseNext;
      timerOut_reg <= (stateNext == TMR_DUR);
      busy_reg     <= (stateNext != TMR_IDLE);
    end
  end

  assign timerOut = timerOut_reg;
  assign busy     = busy_reg;

  chk_trig_start: assert property (@(posedge clock) disable iff (!rstn)
    (trigger && state_reg == TMR_IDLE) |=> (state_reg != TMR_IDLE) && busy)
    else $error("timer did not start on exposure start");
  chk_zero_delay: assert property (@(posedge clock) disable iff (!rstn)
    (trigger && state_reg == TMR_IDLE && zeroDelay) |=> timerOut)
    else $error("zero delay did not raise timer at once");
  chk_busy_ignore: assert property (@(posedge clock) disable iff (!rstn)
    (trigger && state_reg == TMR_DELAY && !tick) |=> (state_reg == TMR_DELAY)
      && $stable(unitCnt_reg))
    else $error("trigger disturbed running timer");
  chk_tick_spacing: assert property (@(posedge clock) disable iff (!rstn)
    tick |=> !tick)
    else $error("microsecond tick too frequent");
  chk_delay_low: assert property (@(posedge clock) disable iff (!rstn)
    (state_reg == TMR_DELAY) |-> !timerOut)
    else $error("timer high during delay");
endmodule

/* File: hdl/olst_top.sv */
// output line source multiplexer, inverter and timer with an AXI4-Lite register slave
//
// Added by the designer: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ns
`include "olst_defines.svh"
module olst_top import olst_pkg::*; #(
  parameter int ADDR_W      = 8,
  parameter int TICK_CYCLES = `OLST_TICK_CYCLES
) (
  // system
  input  wire logic              clock,
  input  wire logic              rstn,
  // camera signals
  input  wire logic              acqTriggerWait,
  input  wire logic              triggerReady,
  input  wire logic              exposureActive,
  // output line
  output logic                   lineOut,
  // axi write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // axi write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // axi write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // axi read data
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);
  olst_cfg_s   cfg_reg;
  olst_tmr_s   tmr_reg;
  olst_abs_t   durAbs_reg;
  logic        lineOut_reg;
  logic        expPrev_reg;
  logic        timerOut;
  logic        timerBusy;

  logic [ADDR_W-1:0] awAddr_reg;
  logic [31:0]       wData_reg;
  logic [3:0]        wStrb_reg;
  logic              awHeld_reg;
  logic              wHeld_reg;
  logic              awReady_reg;
  logic              wReady_reg;
  logic              bValid_reg;
  logic [1:0]        bResp_reg;
  logic              arReady_reg;
  logic              rValid_reg;
  logic [1:0]        rResp_reg;
  logic [31:0]       rData_reg;

  function automatic logic isMapped(input logic [ADDR_W-1:0] a);
    isMapped = (a[1:0] == 2'b00) && (a[7:0] <= `OLST_ADDR_STATUS);
  endfunction

  function automatic logic [31:0] mergeBytes(input logic [31:0] old,
                                             input logic [31:0] nu,
                                             input logic [3:0]  strb);
    for (int i = 0; i < 4; i++) begin
      old[8*i +: 8] = strb[i] ? nu[8*i +: 8] : old[8*i +: 8];
    end
    mergeBytes = old;
  endfunction

  // ---- line source selection
  wire logic       expStart = exposureActive && !expPrev_reg;
  wire logic [2:0] srcSel   = cfg_reg.src;
  wire logic       srcLevel =
    (srcSel == SRC_ACQ_WAIT)   ? (cfg_reg.stdMode && acqTriggerWait) :
    (srcSel == SRC_TRIG_READY) ? triggerReady :
    (srcSel == SRC_EXP_ACTIVE) ? exposureActive :
    (srcSel == SRC_TIMER)      ? timerOut :
    (srcSel == SRC_USER)       ? cfg_reg.userLevel : 1'b0;
  wire logic       lineNext = srcLevel ^ cfg_reg.invert;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      lineOut_reg <= 1'b0;
      expPrev_reg <= 1'b0;
    end else begin
      lineOut_reg <= lineNext;
      expPrev_reg <= exposureActive;
    end
  end

  olst_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_timer (
    .clock    (clock),
    .rstn     (rstn),
    .trigger  (expStart),
    .set      (tmr_reg),
    .timerOut (timerOut),
    .busy     (timerBusy)
  );

  // ---- write path decode
  wire logic        doWrite  = awHeld_reg && wHeld_reg && !bValid_reg;
  wire logic        wrOk     = isMapped(awAddr_reg);
  wire logic [7:0]  wrAddr   = 8'(awAddr_reg);
  wire logic [31:0] wrCtrl   = mergeBytes({26'h0, cfg_reg}, wData_reg, wStrb_reg);
  wire logic [31:0] wrDlyRaw = mergeBytes({20'h0, tmr_reg.delayRaw}, wData_reg, wStrb_reg);
  wire logic [31:0] wrDlyTb  = mergeBytes({16'h0, tmr_reg.delayTb}, wData_reg, wStrb_reg);
  wire logic [31:0] wrDurRaw = mergeBytes({20'h0, tmr_reg.durRaw}, wData_reg, wStrb_reg);
  wire logic [31:0] wrDurTb  = mergeBytes({16'h0, tmr_reg.durTb}, wData_reg, wStrb_reg);
  wire logic [31:0] wrDurAbs = mergeBytes({4'h0, durAbs_reg}, wData_reg, wStrb_reg);
  // raw from absolute value; writer keeps it a multiple of the base
  wire logic [31:0] absQuot  = wrDurAbs / {16'h0, tmr_reg.durTb};
  wire olst_raw_t   absRaw   =
    (absQuot == 32'h0) ? 12'h001 :
    (absQuot > {20'h0, `OLST_RAW_MAX}) ? `OLST_RAW_MAX : absQuot[11:0];
  wire olst_raw_t   durRawWr = (wrDurRaw[11:0] == 12'h000) ? 12'h001 : wrDurRaw[11:0];
  wire olst_tb_t    dlyTbWr  = (wrDlyTb[15:0] == 16'h0000) ? 16'h0001 : wrDlyTb[15:0];
  wire olst_tb_t    durTbWr  = (wrDurTb[15:0] == 16'h0000) ? 16'h0001 : wrDurTb[15:0];

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cfg_reg <= '{src: `OLST_RST_SRC, invert: 1'b0, userLevel: 1'b0,
                   stdMode: 1'b1};
      tmr_reg <= '{delayRaw: `OLST_RST_DELAY_RAW, delayTb: `OLST_RST_TB,
                   durRaw: `OLST_RST_DUR_RAW, durTb: `OLST_RST_TB};
    end else if (doWrite && wrOk) begin
      unique case (wrAddr)
        `OLST_ADDR_CTRL:      cfg_reg          <= olst_cfg_s'(wrCtrl[5:0]);
        `OLST_ADDR_DELAY_RAW: tmr_reg.delayRaw <= wrDlyRaw[11:0];
        `OLST_ADDR_DELAY_TB:  tmr_reg.delayTb  <= dlyTbWr;
        `OLST_ADDR_DUR_RAW:   tmr_reg.durRaw   <= durRawWr;
        `OLST_ADDR_DUR_TB:    tmr_reg.durTb    <= durTbWr;
        `OLST_ADDR_DUR_ABS:   tmr_reg.durRaw   <= absRaw;
        default: begin
        end
      endcase
    end
  end

  // absolute duration is registered raw times base, one cycle after either changes
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      durAbs_reg <= 28'h0000001;
    end else begin
      durAbs_reg <= tmr_reg.durRaw * tmr_reg.durTb;
    end
  end

  // ---- write channel handshakes
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      awHeld_reg  <= 1'b0;
      awReady_reg <= 1'b1;
      awAddr_reg  <= '0;
    end else if (s_axi_awvalid && awReady_reg) begin
      awHeld_reg  <= 1'b1;
      awReady_reg <= 1'b0;
      awAddr_reg  <= s_axi_awaddr;
    end else if (doWrite) begin
      awHeld_reg  <= 1'b0;
      awReady_reg <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wHeld_reg  <= 1'b0;
      wReady_reg <= 1'b1;
      wData_reg  <= 32'h00000000;
      wStrb_reg  <= 4'h0;
    end else if (s_axi_wvalid && wReady_reg) begin
      wHeld_reg  <= 1'b1;
      wReady_reg <= 1'b0;
      wData_reg  <= s_axi_wdata;
      wStrb_reg  <= s_axi_wstrb;
    end else if (doWrite) begin
      wHeld_reg  <= 1'b0;
      wReady_reg <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      bValid_reg <= 1'b0;
      bResp_reg  <= `OLST_RESP_OKAY;
    end else if (doWrite) begin
      bValid_reg <= 1'b1;
      bResp_reg  <= wrOk ? `OLST_RESP_OKAY : `OLST_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bValid_reg <= 1'b0;
    end
  end

  // ---- read path
  wire logic [7:0]  rdAddr   = 8'(s_axi_araddr);
  wire logic        rdOk     = isMapped(s_axi_araddr);
  wire logic [31:0] rdStatus = {29'h0, timerBusy, timerOut, lineOut_reg};
  wire logic [31:0] rdMux    =
    !rdOk                            ? 32'h00000000 :
    (rdAddr == `OLST_ADDR_CTRL)      ? {26'h0, cfg_reg} :
    (rdAddr == `OLST_ADDR_DELAY_RAW) ? {20'h0, tmr_reg.delayRaw} :
    (rdAddr == `OLST_ADDR_DELAY_TB)  ? {16'h0, tmr_reg.delayTb} :
    (rdAddr == `OLST_ADDR_DUR_RAW)   ? {20'h0, tmr_reg.durRaw} :
    (rdAddr == `OLST_ADDR_DUR_TB)    ? {16'h0, tmr_reg.durTb} :
    (rdAddr == `OLST_ADDR_DUR_ABS)   ? {4'h0, durAbs_reg} :
    rdStatus;
  wire logic        rdTake   = s_axi_arvalid && arReady_reg;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      arReady_reg <= 1'b1;
      rValid_reg  <= 1'b0;
      rResp_reg   <= `OLST_RESP_OKAY;
      rData_reg   <= 32'h00000000;
    end else if (rdTake) begin
      arReady_reg <= 1'b0;
      rValid_reg  <= 1'b1;
      rResp_reg   <= rdOk ? `OLST_RESP_OKAY : `OLST_RESP_SLVERR;
      rData_reg   <= rdMux;
    end else if (rValid_reg && s_axi_rready) begin
      arReady_reg <= 1'b1;
      rValid_reg  <= 1'b0;
    end
  end

  assign lineOut       = lineOut_reg;
  assign s_axi_awready = awReady_reg;
  assign s_axi_wready  = wReady_reg;
  assign s_axi_bvalid  = bValid_reg;
  assign s_axi_bresp   = bResp_reg;
  assign s_axi_arready = arReady_reg;
  assign s_axi_rvalid  = rValid_reg;
  assign s_axi_rresp   = rResp_reg;
  assign s_axi_rdata   = rData_reg;

  chk_line_invert: assert property (@(posedge clock) disable iff (!rstn)
    (cfg_reg.src == SRC_EXP_ACTIVE) ##1 (cfg_reg.src == SRC_EXP_ACTIVE)
      |-> lineOut == ($past(exposureActive) ^ $past(cfg_reg.invert)))
    else $error("line does not follow inverted exposure active");
  chk_user_level: assert property (@(posedge clock) disable iff (!rstn)
    (cfg_reg.src == SRC_USER) |=> lineOut == ($past(cfg_reg.userLevel)
      ^ $past(cfg_reg.invert)))
    else $error("user level not placed ahead of inverter");
  chk_legacy_wait: assert property (@(posedge clock) disable iff (!rstn)
    (cfg_reg.src == SRC_ACQ_WAIT && !cfg_reg.stdMode) |=> lineOut == $past(cfg_reg.invert))
    else $error("trigger wait passed in legacy mode");
  chk_dur_range: assert property (@(posedge clock) disable iff (!rstn)
    tmr_reg.durRaw != 12'h000)
    else $error("raw duration reached zero");
  chk_tb_min: assert property (@(posedge clock) disable iff (!rstn)
    (tmr_reg.delayTb != 16'h0000) && (tmr_reg.durTb != 16'h0000))
    else $error("time base below one microsecond");
  chk_abs_follow: assert property (@(posedge clock) disable iff (!rstn)
    $changed(tmr_reg.durRaw) |=> durAbs_reg == 28'($past(tmr_reg.durRaw) * $past(tmr_reg.durTb)))
    else $error("absolute duration did not follow raw count");
  chk_write_resp: assert property (@(posedge clock) disable iff (!rstn)
    doWrite |=> s_axi_bvalid ##0 (s_axi_bresp == (isMapped($past(awAddr_reg))
      ? `OLST_RESP_OKAY : `OLST_RESP_SLVERR)))
    else $error("write response missing or wrong");
  chk_timer_source: assert property (@(posedge clock) disable iff (!rstn)
    (cfg_reg.src == SRC_TIMER) |=>
      lineOut == ($past(timerOut) ^ $past(cfg_reg.invert)))
    else $error("line does not follow timer output");
  chk_trig_ready: assert property (@(posedge clock) disable iff (!rstn)
    (cfg_reg.src == SRC_TRIG_READY) |=>
      lineOut == ($past(triggerReady) ^ $past(cfg_reg.invert)))
    else $error("line does not follow trigger ready");
  chk_std_wait: assert property (@(posedge clock) disable iff (!rstn)
    (cfg_reg.src == SRC_ACQ_WAIT && cfg_reg.stdMode) |=>
      lineOut == ($past(acqTriggerWait) ^ $past(cfg_reg.invert)))
    else $error("trigger wait not passed in standard mode");
  chk_abs_write: assert property (@(posedge clock) disable iff (!rstn)
    (doWrite && wrOk && (wrAddr == `OLST_ADDR_DUR_ABS) && (absQuot != 32'h00000000)
      && (absQuot <= 32'h00000FFF) && ((wrDurAbs % {16'h0, tmr_reg.durTb}) == 32'h00000000))
      |=> ##1 (durAbs_reg == $past(wrDurAbs[27:0], 2)))
    else $error("absolute duration write not kept");
  chk_raw_clamp: assert property (@(posedge clock) disable iff (!rstn)
    (doWrite && wrOk && (wrAddr == `OLST_ADDR_DUR_RAW) && (wrDurRaw[11:0] == 12'h000))
      |=> (tmr_reg.durRaw == 12'h001))
    else $error("zero raw duration not raised to one");
endmodule

/* File: test/olst_line_monitor.sv */
// external load watching the output line and timing its high pulses
`timescale 1ns/1ns
module olst_line_monitor (
  // system
  input  wire logic clock,
  // watched line
  input  wire logic lineOut,
  // measurements
  output int        pulses,
  output int        riseAt,
  output int        width
);
  int   cnt;
  logic lastLevel;

  initial begin
    cnt = 0;
    pulses = 0;
    riseAt = 0;
    width = 0;
    lastLevel = 1'b0;
  end

  // a pulse counts once it has ended
  always @(posedge clock) begin
    cnt <= cnt + 1;
    lastLevel <= lineOut;
    if (lineOut === 1'b1 && lastLevel !== 1'b1) begin
      riseAt <= cnt;
    end
    if (lineOut !== 1'b1 && lastLevel === 1'b1) begin
      width <= cnt - riseAt;
      pulses <= pulses + 1;
    end
  end
endmodule

/* File: test/test_output_line_source_timer.sv */
// self-checking bench of the output line source and timer block
`timescale 1ns/1ns
`include "olst_defines.svh"
module test_output_line_source_timer import olst_pkg::*;;
  localparam int TK = 4;
  typedef struct packed {
    logic [31:0] data;
    logic [1:0]  resp;
  } olst_exp_s;

  logic        clock, rstn, acqTriggerWait, triggerReady, exposureActive, lineOut;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, pre;
  logic [15:0] rnd;
  int          n_fail, num_checks, cyc, pulses, riseAt, width;
  olst_exp_s   expQ[$];
  olst_exp_s   ex;
  logic [7:0]  rAddr [7] = '{`OLST_ADDR_CTRL, `OLST_ADDR_DELAY_RAW, `OLST_ADDR_DELAY_TB,
                             `OLST_ADDR_DUR_RAW, `OLST_ADDR_DUR_TB, `OLST_ADDR_DUR_ABS,
                             `OLST_ADDR_STATUS};
  logic [31:0] rVal [7] = '{32'h22, 32'h0, 32'h1, 32'h1, 32'h1, 32'h1, 32'h1};

  olst_top #(.TICK_CYCLES(TK)) u_olst_top (
    .clock(clock), .rstn(rstn), .acqTriggerWait(acqTriggerWait),
    .triggerReady(triggerReady), .exposureActive(exposureActive), .lineOut(lineOut),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
  );

  olst_line_monitor u_olst_line_monitor (
    .clock(clock), .lineOut(lineOut), .pulses(pulses), .riseAt(riseAt), .width(width)
  );

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic cmp(input logic [31:0] got, input logic [31:0] want, input string msg);
    num_checks++;
    if (got !== want) begin
      n_fail++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, msg, got, want);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic axiWr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    expQ.push_back({32'h0, r});
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clock);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask

  task automatic axiRd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    expQ.push_back({d, r});
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clock);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask

  task automatic lineIs(input logic e);
    repeat (3) @(posedge clock);
    cmp({31'h0, lineOut}, {31'h0, e}, "line level");
  endtask

  // other inputs toggling first, then one exposure start, optional retrigger
  task automatic pulse(input int dly, input int wid, input bit retrig);
    int n0;
    int tTrig;
    int k;
    exposureActive <= 1'b0;
    n0 = pulses;
    repeat (20) begin
      @(posedge clock);
      rnd = lfsr(rnd);
      acqTriggerWait <= rnd[0];
      triggerReady <= rnd[1];
    end
    repeat ((dly + wid + 2) * TK) @(posedge clock);
    cmp(pulses, n0, "timer started by other input");
    exposureActive <= 1'b1;
    tTrig = cyc;
    if (retrig) begin
      repeat (3) @(posedge clock);
      exposureActive <= 1'b0;
      repeat (3) @(posedge clock);
      exposureActive <= 1'b1;
    end
    k = 0;
    while (pulses == n0 && k < 60000) begin
      @(posedge clock);
      k++;
    end
    cmp(width, wid * TK, "pulse width");
    k = riseAt - tTrig;
    cmp({31'h0, k >= dly * TK - TK && k <= dly * TK + 4}, 32'h1, "delay");
    repeat ((dly + wid) * TK + 20) @(posedge clock);
    cmp(pulses, n0 + 1, "pulse count");
  endtask

  task automatic endTest(input string nm);
    $display("test %s finished, checks %0d", nm, num_checks);
  endtask

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  always @(posedge clock) cyc <= cyc + 1;

  // compares each bus answer with the oldest noted expectation
  always @(posedge clock) begin
    if ((bvalid === 1'b1 && bready) || (rvalid === 1'b1 && rready)) begin
      ex = (expQ.size() > 0) ? expQ.pop_front() : '1;
      if (rvalid === 1'b1) begin
        cmp(rdata, ex.data, "read data");
        cmp({30'h0, rresp}, {30'h0, ex.resp}, "read response");
      end else begin
        cmp({30'h0, bresp}, {30'h0, ex.resp}, "write response");
      end
    end
  end

  initial begin
    repeat (30000) @(posedge clock);
    n_fail++;
    wrap_up();
  end

  initial begin
    {rstn, acqTriggerWait, triggerReady, awaddr, araddr, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    exposureActive = 1'b1;
    rnd = 16'h2237;
    n_fail = 0;
    num_checks = 0;
    cyc = 0;
    repeat (10) @(posedge clock);
    rstn <= 1'b1;
    lineIs(1'b1);
    for (int i = 0; i < 7; i++) begin
      axiRd(rAddr[i], rVal[i], `OLST_RESP_OKAY);
    end
    axiRd(8'h1C, 32'h0, `OLST_RESP_SLVERR);
    axiRd(8'h02, 32'h0, `OLST_RESP_SLVERR);
    axiWr(8'h1C, 32'hFF, `OLST_RESP_SLVERR);
    endTest("reset and map");
    for (int m = 0; m < 2; m++) begin
      for (int s = 0; s < 8; s++) begin
        for (int v = 0; v < 2; v++) begin
          rnd = lfsr(rnd);
          acqTriggerWait <= rnd[0];
          triggerReady <= rnd[1];
          exposureActive <= rnd[2];
          axiWr(`OLST_ADDR_CTRL, {26'h0, m[0], rnd[3], v[0], s[2:0]}, `OLST_RESP_OKAY);
          repeat (12) @(posedge clock);
          case (s)
            0: pre = m[0] & rnd[0];
            1: pre = rnd[1];
            2: pre = rnd[2];
            4: pre = rnd[3];
            default: pre = 1'b0;
          endcase
          lineIs(pre ^ v[0]);
        end
      end
    end
    endTest("source select");
    axiWr(`OLST_ADDR_DUR_TB, 32'h3, `OLST_RESP_OKAY);
    axiWr(`OLST_ADDR_DUR_ABS, 32'hC, `OLST_RESP_OKAY);
    axiRd(`OLST_ADDR_DUR_RAW, 32'h4, `OLST_RESP_OKAY);
    axiRd(`OLST_ADDR_DUR_ABS, 32'hC, `OLST_RESP_OKAY);
    axiWr(`OLST_ADDR_DUR_RAW, 32'h7, `OLST_RESP_OKAY);
    axiRd(`OLST_ADDR_DUR_ABS, 32'h15, `OLST_RESP_OKAY);
    axiWr(`OLST_ADDR_DELAY_RAW, 32'hFFF, `OLST_RESP_OKAY);
    axiRd(`OLST_ADDR_DELAY_RAW, 32'hFFF, `OLST_RESP_OKAY);
    axiWr(`OLST_ADDR_DUR_RAW, 32'h0, `OLST_RESP_OKAY);
    axiRd(`OLST_ADDR_DUR_RAW, 32'h1, `OLST_RESP_OKAY);
    endTest("duration settings");
    axiWr(`OLST_ADDR_CTRL, 32'h23, `OLST_RESP_OKAY);
    axiWr(`OLST_ADDR_DELAY_RAW, 32'h3, `OLST_RESP_OKAY);
    axiWr(`OLST_ADDR_DELAY_TB, 32'h2, `OLST_RESP_OKAY);
    axiWr(`OLST_ADDR_DUR_RAW, 32'h5, `OLST_RESP_OKAY);
    axiWr(`OLST_ADDR_DUR_TB, 32'h1, `OLST_RESP_OKAY);
    pulse(6, 5, 1'b1);
    axiWr(`OLST_ADDR_DELAY_RAW, 32'h0, `OLST_RESP_OKAY);
    axiWr(`OLST_ADDR_DUR_TB, 32'h3, `OLST_RESP_OKAY);
    axiWr(`OLST_ADDR_DUR_RAW, 32'h2, `OLST_RESP_OKAY);
    pulse(0, 6, 1'b0);
    endTest("timer");
    wrap_up();
  end
endmodule
